// ==== hdl/qssc_pkg.sv ====
// constants, types and register map of the queued serial sequencer
package qssc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_CTRL3 = 8'h0C;
  localparam logic [7:0] ADDR_PORT = 8'h10;
  localparam logic [7:0] ADDR_DATA = 8'h14;
  localparam logic [1:0] CMD_PAGE = 2'h1;
  // reset values
  localparam logic [15:0] CTRL0_RST = 16'h0104;
  localparam logic [6:0] DELAY_BEFORE_CLOCK_FIELD_RST = 7'h04;
  localparam logic [7:0] DTL_RST = 8'h04;
  // field positions
  localparam int CTRL0_MASTER_SELECT_BIT = 15;
  localparam int CTRL0_CPOL = 9;
  localparam int CTRL0_CPHA = 8;
  localparam int BIT_SPE = 15;
  localparam int BIT_FINIE = 15;
  localparam int BIT_WRAPAROUND_ENABLE = 14;
  localparam int BIT_WRAP_TO_SELECT = 13;
  localparam int BIT_LOOP = 10;
  localparam int BIT_HALT_FAULT_IRQ_ENABLE = 9;
  localparam int BIT_HALT = 8;
  localparam int BIT_FIN = 7;
  localparam int BIT_MODE_FAULT_FLAG = 6;
  localparam int BIT_HALT_ACKNOWLEDGE_FLAG = 5;
  // pin indices
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_PCS0 = 3;
  // timing in system clock periods, transfer widths in bits
  localparam logic [7:0] DELAY_BEFORE_CLOCK_FIELD_ZERO = 8'h80;
  localparam logic [13:0] DTL_SCALE = 14'h0020;
  localparam logic [13:0] DTL_ZERO = 14'h0100;
  localparam logic [7:0] BAUD_MIN = 8'h02;
  localparam logic [4:0] WIDTH_FULL = 5'h10;
  localparam logic [4:0] WIDTH_BYTE = 5'h08;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_SETUP = 3'b010,
    ST_SHIFT = 3'b011,
    ST_POST = 3'b100,
    ST_NEXT = 3'b101,
    ST_HALT = 3'b110
  } qssc_state_type;
  typedef struct packed {
    logic continue_select_bit;
    logic width_enable_bit;
    logic dt;
    logic clock_delay_bit;
    logic [3:0] pcs;
  } qssc_cmd_type;
endpackage

// ==== hdl/qssc_top.sv ====
// queued serial sequencer: ahb-lite registers, command queue, shifter
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module qssc_top
  import qssc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe,
  output logic irq
);
  logic wr_pend_reg, rd_pend_reg, hreadyout_reg, hresp_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg, rd_mux;
  logic [15:0] ctrl0_reg;
  logic spe_reg;
  logic [6:0] delay_before_clock_field_reg;
  logic [7:0] dtl_reg;
  logic finie_reg, wraparound_enable_reg, wrap_to_select_reg;
  logic [3:0] ending_queue_pointer_reg, start_queue_pointer_reg, completed_queue_pointer_reg, qp_reg;
  logic loop_reg, halt_fault_irq_enable_reg, halt_reg;
  logic fin_reg, mode_fault_flag_reg, halt_acknowledge_flag_reg;
  logic [6:0] pdata_reg, assign_reg, dir_reg;
  logic [15:0] tx_data_reg, rx_data_reg, tx_sh_reg, rx_sh_reg;
  logic [7:0] ram [0:15];
  qssc_state_type state_reg, prev_state_reg;
  qssc_cmd_type cmd_reg, ram_cmd;
  logic [13:0] cnt_reg, setup_len_reg, post_len_reg, hold_h_reg;
  logic [7:0] div_reg;
  logic [5:0] edge_reg;
  logic sck_reg, cs_active_reg;
  logic [3:0] cs_val_reg;
  logic [6:0] pin_s1_reg, pin_s2_reg, pin_out_reg, pin_oe_reg;
  logic irq_reg;
  logic acc, wr, master, cpha, last_entry, step, lead, sample, shift;
  logic set_fin, set_mode_fault_flag, set_halt_acknowledge_flag, spe_clr, miso_eff;
  logic [7:0] baud;
  logic [4:0] bits;
  logic [5:0] edges;
  logic [6:0] own, q_out, q_oe;
  logic [13:0] hold_cur;

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = hresp_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign irq = irq_reg;

  // bus decode; reads take one wait state so hrdata comes from a flop
  assign acc = hsel & htrans[1] & hready;
  assign wr = wr_pend_reg;
  assign master = ctrl0_reg[CTRL0_MASTER_SELECT_BIT];
  assign cpha = ctrl0_reg[CTRL0_CPHA];
  assign baud = (ctrl0_reg[7:0] < BAUD_MIN) ? BAUD_MIN : ctrl0_reg[7:0];
  assign ram_cmd = qssc_cmd_type'(ram[qp_reg]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= acc & hwrite;
      rd_pend_reg <= acc & ~hwrite;
      if (acc) begin
        addr_reg <= haddr[7:0];
      end
      hreadyout_reg <= ~(acc & ~hwrite);
      if (rd_pend_reg) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_reg[7:6] == CMD_PAGE) begin
      rd_mux = {24'h00_0000, ram[addr_reg[5:2]]};
    end else begin
      case (addr_reg)
        ADDR_CTRL0: rd_mux = {16'h0000, ctrl0_reg};
        ADDR_CTRL1: rd_mux = {16'h0000, spe_reg, delay_before_clock_field_reg, dtl_reg};
        ADDR_CTRL2: rd_mux = {16'h0000, finie_reg, wraparound_enable_reg, wrap_to_select_reg, 1'b0,
                              ending_queue_pointer_reg, 4'h0, start_queue_pointer_reg};
        ADDR_CTRL3: rd_mux = {21'h00_0000, loop_reg, halt_fault_irq_enable_reg, halt_reg,
                              fin_reg, mode_fault_flag_reg, halt_acknowledge_flag_reg, 1'b0, completed_queue_pointer_reg};
        ADDR_PORT: rd_mux = {9'h000, dir_reg, 1'b0, assign_reg, 1'b0, pdata_reg};
        ADDR_DATA: rd_mux = {16'h0000, rx_data_reg};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // control registers; ctrl0, the delay field and dtl load their reset values, all other control bits clear at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_reg <= CTRL0_RST;
      delay_before_clock_field_reg <= DELAY_BEFORE_CLOCK_FIELD_RST;
      dtl_reg <= DTL_RST;
      {finie_reg, wraparound_enable_reg, wrap_to_select_reg} <= 3'h0;
      ending_queue_pointer_reg <= 4'h0;
      start_queue_pointer_reg <= 4'h0;
      {loop_reg, halt_fault_irq_enable_reg, halt_reg} <= 3'h0;
      pdata_reg <= 7'h00;
      assign_reg <= 7'h00;
      dir_reg <= 7'h00;
      tx_data_reg <= 16'h0000;
    end else if (wr) begin
      case (addr_reg)
        ADDR_CTRL0: ctrl0_reg <= hwdata[15:0];
        ADDR_CTRL1: begin
          delay_before_clock_field_reg <= hwdata[14:8];
          dtl_reg <= hwdata[7:0];
        end
        ADDR_CTRL2: begin
          finie_reg <= hwdata[BIT_FINIE];
          wraparound_enable_reg <= hwdata[BIT_WRAPAROUND_ENABLE];
          wrap_to_select_reg <= hwdata[BIT_WRAP_TO_SELECT];
          ending_queue_pointer_reg <= hwdata[11:8];
          start_queue_pointer_reg <= hwdata[3:0];
        end
        ADDR_CTRL3: begin
          loop_reg <= hwdata[BIT_LOOP];
          halt_fault_irq_enable_reg <= hwdata[BIT_HALT_FAULT_IRQ_ENABLE];
          halt_reg <= hwdata[BIT_HALT];
        end
        ADDR_PORT: begin
          pdata_reg <= hwdata[6:0];
          assign_reg <= hwdata[14:8];
          dir_reg <= hwdata[22:16];
        end
        ADDR_DATA: tx_data_reg <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // command queue memory, low byte of each word
  always_ff @(posedge hclk) begin
    if (wr && addr_reg[7:6] == CMD_PAGE) begin
      ram[addr_reg[5:2]] <= hwdata[7:0];
    end
  end

  // enable: software sets it, finishing without wrap or a fault clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spe_reg <= 1'b0;
    end else if (spe_clr) begin
      spe_reg <= 1'b0;
    end else if (wr && addr_reg == ADDR_CTRL1) begin
      spe_reg <= hwdata[BIT_SPE];
    end
  end

  // pin input synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= 7'h7F;
      pin_s2_reg <= 7'h7F;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // transfer width and edge bookkeeping
  always_comb begin
    bits = WIDTH_BYTE;
    if (cmd_reg.width_enable_bit) begin
      bits = ctrl0_reg[13] ? {2'b00, ctrl0_reg[12:10]} + WIDTH_BYTE : WIDTH_FULL;
    end
  end
  assign edges = {bits, 1'b0};
  assign last_entry = (qp_reg == ending_queue_pointer_reg);
  assign step = (state_reg == ST_SHIFT) && (div_reg == 8'h01);
  assign lead = ~edge_reg[0];
  assign sample = lead ^ cpha;
  assign shift = ~sample & ~(cpha & (edge_reg == 6'h00));
  assign miso_eff = loop_reg ? tx_sh_reg[15] : pin_s2_reg[PIN_MISO];
  assign set_fin = (state_reg == ST_NEXT) && last_entry;
  assign set_halt_acknowledge_flag = (state_reg == ST_NEXT) && halt_reg && !(last_entry && !wraparound_enable_reg);
  assign set_mode_fault_flag = spe_reg && master && !dir_reg[PIN_PCS0] &&
                    !pin_s2_reg[PIN_PCS0];
  assign spe_clr = set_mode_fault_flag || (set_fin && !wraparound_enable_reg);

  // queue sequencer: load entry, select setup, shift, post delay, advance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      qp_reg <= 4'h0;
      completed_queue_pointer_reg <= 4'h0;
      cmd_reg <= '0;
      cnt_reg <= 14'h0000;
      setup_len_reg <= 14'h0000;
      post_len_reg <= 14'h0000;
      div_reg <= 8'h00;
      edge_reg <= 6'h00;
      sck_reg <= 1'b0;
      cs_active_reg <= 1'b0;
      cs_val_reg <= 4'h0;
      tx_sh_reg <= 16'h0000;
      rx_sh_reg <= 16'h0000;
      rx_data_reg <= 16'h0000;
    end else if (!spe_reg || !master) begin
      // disabled or passive: drop selects and park the clock
      state_reg <= ST_IDLE;
      cs_active_reg <= 1'b0;
      sck_reg <= ctrl0_reg[CTRL0_CPOL];
      qp_reg <= start_queue_pointer_reg;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          qp_reg <= start_queue_pointer_reg;
          state_reg <= ST_LOAD;
        end
        ST_LOAD: begin
          cmd_reg <= ram_cmd;
          cs_active_reg <= 1'b1;
          cs_val_reg <= ram_cmd.pcs;
          tx_sh_reg <= tx_data_reg;
          sck_reg <= ctrl0_reg[CTRL0_CPOL];
          if (ram_cmd.clock_delay_bit) begin
            setup_len_reg <= (delay_before_clock_field_reg == 7'h00) ? {6'h00, DELAY_BEFORE_CLOCK_FIELD_ZERO} :
                             {7'h00, delay_before_clock_field_reg};
            cnt_reg <= (delay_before_clock_field_reg == 7'h00) ? {6'h00, DELAY_BEFORE_CLOCK_FIELD_ZERO} :
                       {7'h00, delay_before_clock_field_reg};
          end else begin
            setup_len_reg <= {6'h00, baud};
            cnt_reg <= {6'h00, baud};
          end
          if (ram_cmd.dt) begin
            post_len_reg <= (dtl_reg == 8'h00) ? DTL_ZERO * DTL_SCALE :
                            {6'h00, dtl_reg} * DTL_SCALE;
          end else begin
            post_len_reg <= 14'h0001;
          end
          state_reg <= ST_SETUP;
        end
        ST_SETUP: begin
          // left-justify so the first bit of any width sits at the top
          if (cnt_reg == 14'h0001) begin
            tx_sh_reg <= tx_sh_reg << (WIDTH_FULL - bits);
            div_reg <= baud;
            edge_reg <= 6'h00;
            state_reg <= ST_SHIFT;
          end else begin
            cnt_reg <= cnt_reg - 14'h0001;
          end
        end
        ST_SHIFT: begin
          if (step) begin
            sck_reg <= ~sck_reg;
            edge_reg <= edge_reg + 6'h01;
            div_reg <= baud;
            if (sample) begin
              rx_sh_reg <= {rx_sh_reg[14:0], miso_eff};
            end
            if (shift) begin
              tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
            end
            if (edge_reg == edges - 6'h01) begin
              cs_active_reg <= cmd_reg.continue_select_bit;
              cnt_reg <= post_len_reg;
              state_reg <= ST_POST;
            end
          end else begin
            div_reg <= div_reg - 8'h01;
          end
        end
        ST_POST: begin
          if (cnt_reg == 14'h0001) begin
            state_reg <= ST_NEXT;
          end else begin
            cnt_reg <= cnt_reg - 14'h0001;
          end
        end
        ST_NEXT: begin
          // a whole entry is done here, the only place a halt may land
          rx_data_reg <= rx_sh_reg;
          completed_queue_pointer_reg <= qp_reg;
          if (last_entry) begin
            qp_reg <= wrap_to_select_reg ? start_queue_pointer_reg : 4'h0;
          end else begin
            qp_reg <= qp_reg + 4'h1;
          end
          if (last_entry && !wraparound_enable_reg) begin
            state_reg <= ST_IDLE;
          end else if (halt_reg) begin
            state_reg <= ST_HALT;
          end else begin
            state_reg <= ST_LOAD;
          end
        end
        ST_HALT: begin
          if (!halt_reg) begin
            state_reg <= ST_LOAD;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // status flags: hardware set wins over a software write of zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fin_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      halt_acknowledge_flag_reg <= 1'b0;
    end else begin
      if (set_fin) begin
        fin_reg <= 1'b1;
      end else if (wr && addr_reg == ADDR_CTRL3 && !hwdata[BIT_FIN]) begin
        fin_reg <= 1'b0;
      end
      if (set_mode_fault_flag) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (wr && addr_reg == ADDR_CTRL3 && !hwdata[BIT_MODE_FAULT_FLAG]) begin
        mode_fault_flag_reg <= 1'b0;
      end
      if (set_halt_acknowledge_flag) begin
        halt_acknowledge_flag_reg <= 1'b1;
      end else if (wr && addr_reg == ADDR_CTRL3 && !hwdata[BIT_HALT_ACKNOWLEDGE_FLAG]) begin
        halt_acknowledge_flag_reg <= 1'b0;
      end
    end
  end

  // interrupt request gated by the two enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (fin_reg & finie_reg) | ((halt_acknowledge_flag_reg | mode_fault_flag_reg) & halt_fault_irq_enable_reg);
    end
  end

  // pin ownership: sck follows the enable alone, others need assignment
  always_comb begin
    own = spe_reg ? (assign_reg | 7'h04) : 7'h00;
    q_out = {cs_active_reg ? cs_val_reg : pdata_reg[6:3], sck_reg,
             tx_sh_reg[15], 1'b0};
    // pcs0 left as input when its direction bit is clear, so a pulled-low select is seen
    q_oe = {master, master, master, master & dir_reg[PIN_PCS0], master, master, 1'b0};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_reg <= 7'h00;
      pin_oe_reg <= 7'h00;
    end else begin
      pin_out_reg <= (own & q_out) | (~own & pdata_reg);
      pin_oe_reg <= (own & q_oe) | (~own & dir_reg);
    end
  end

  // helper for assertions: cycles spent in the current state, this one included
  assign hold_cur = (state_reg != prev_state_reg) ? 14'h0001 : hold_h_reg + 14'h0001;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_state_reg <= ST_IDLE;
      hold_h_reg <= 14'h0000;
    end else begin
      prev_state_reg <= state_reg;
      hold_h_reg <= hold_cur;
    end
  end

  sequence s_last_done;
    state_reg == ST_NEXT && last_entry;
  endsequence
  sequence s_setup_exit;
    $past(state_reg) == ST_SETUP && state_reg == ST_SHIFT;
  endsequence

  a_setup_len: assert property (@(posedge hclk) disable iff (!hresetn)
    s_setup_exit |-> $past(hold_cur) == setup_len_reg)
    else $error("select to clock delay wrong");
  a_post_len: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(state_reg) == ST_POST && state_reg == ST_NEXT) |->
    $past(hold_cur) == post_len_reg)
    else $error("after-transfer delay wrong");
  a_fin_set: assert property (@(posedge hclk) disable iff (!hresetn)
    s_last_done |=> fin_reg)
    else $error("finished flag not set");
  a_halt_boundary: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(halt_acknowledge_flag_reg) |-> $past(state_reg) == ST_NEXT)
    else $error("halt acknowledged mid-transfer");
  a_completed_queue_pointer_update: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_NEXT |=> completed_queue_pointer_reg == $past(qp_reg))
    else $error("completed pointer not updated");
  a_wrap_target: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_last_done ##0 wraparound_enable_reg && spe_reg && master) |=>
    qp_reg == ($past(wrap_to_select_reg) ? $past(start_queue_pointer_reg) : 4'h0))
    else $error("wraparound target wrong");
  a_loop_path: assert property (@(posedge hclk) disable iff (!hresetn)
    (step && sample && loop_reg && spe_reg && master) |=>
    rx_sh_reg[0] == $past(tx_sh_reg[15]))
    else $error("loop-back path broken");
  a_mode_fault_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    set_mode_fault_flag |=> mode_fault_flag_reg && !spe_reg)
    else $error("mode fault not flagged");
  a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_reg |-> $past(fin_reg && finie_reg) || $past((halt_acknowledge_flag_reg || mode_fault_flag_reg) && halt_fault_irq_enable_reg))
    else $error("interrupt without enabled source");
  a_spe_release: assert property (@(posedge hclk) disable iff (!hresetn)
    !spe_reg |=> pin_oe_reg == $past(dir_reg) && pin_out_reg == $past(pdata_reg))
    else $error("pins not released when disabled");
  a_width_edges: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(state_reg) == ST_SHIFT && state_reg == ST_POST) |->
    edge_reg == {($past(cmd_reg.width_enable_bit) ? bits : WIDTH_BYTE), 1'b0})
    else $error("wrong number of clock edges");
endmodule

// ==== testbench/qssc_spi_peer.sv ====
// spi peripheral model: answers on miso, logs select timing and sck edges
`timescale 1ns/1ps
module qssc_spi_peer
  import qssc_pkg::*;
(
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic ss_low,
  output logic [6:0] pin_in,
  output int frames,
  output int edges,
  output logic [3:0] cs_seen,
  output int setup_cyc,
  output int gap_cyc
);
  localparam real CLK_NS = 50.0;
  logic sck, sel, miso_r, in_fr;
  realtime t_on, t_off;
  assign sck = pin_oe[PIN_SCK] & pin_out[PIN_SCK];
  assign sel = (&pin_oe[6:3]) && (pin_out[6:3] != 4'hF);
  // released pins float to pull-ups; miso and slave-select come from here
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
    if (!pin_oe[PIN_MISO]) pin_in[PIN_MISO] = miso_r;
    if (!pin_oe[PIN_PCS0] && ss_low) pin_in[PIN_PCS0] = 1'b0;
  end
  initial begin
    frames = 0;
    edges = 0;
    miso_r = 1'b0;
    in_fr = 1'b0;
    t_off = 0.0;
  end
  // a frame starts when the select pattern leaves the idle level
  always @(posedge sel) begin
    t_on = $realtime;
    edges = 0;
    in_fr = 1'b1;
    cs_seen = pin_out[6:3];
    gap_cyc = int'((t_on - t_off) / CLK_NS);
  end
  // count every sck transition inside the frame, shift out a new miso bit
  always @(sck) begin
    // frame flag lags the select, so the last edge beside the deselect still counts
    if (in_fr) begin
      if (edges == 0) setup_cyc = int'(($realtime - t_on) / CLK_NS);
      edges++;
      miso_r = edges[1] ^ edges[3];
    end
  end
  // deselected: miso must not look like it still holds the last bit
  always @(negedge sel) begin
    t_off = $realtime;
    #1;
    in_fr = 1'b0;
    miso_r = ~miso_r;
    frames++;
  end
endmodule

// ==== testbench/queued_spi_sequencer_control_test.sv ====
// self-checking bench for the queued serial sequencer
`timescale 1ns/1ps
module queued_spi_sequencer_control_test import qssc_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, ss_low, rd_ph;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] pin_in, pin_out, pin_oe;
  logic [3:0] peer_cs, s, p;
  logic [3:0] pc [4];
  int fr_n, peer_edges, peer_setup, peer_gap, base;
  int err_total = 0;
  int checks_done = 0;
  int setup_a [16];
  int gap_a [16];
  logic [63:0] rd_q [$];
  logic [11:0] fr_q [$];
  logic [63:0] e;
  logic [11:0] f;
  qssc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  qssc_spi_peer peer (.pin_out(pin_out), .pin_oe(pin_oe), .ss_low(ss_low),
    .pin_in(pin_in), .frames(fr_n), .edges(peer_edges), .cs_seen(peer_cs),
    .setup_cyc(peer_setup), .gap_cyc(peer_gap));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single ahb-lite transfer; address held until hready, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph <= !wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // notes the masked expectation, the read monitor compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    rd_q.push_back({m, v & m});
    bus(1'b0, a, 32'h00000000);
  endtask
  task automatic cmd(input int i, input logic [7:0] c);
    wr(8'(8'h40 + 4 * i), {24'h000000, c});
  endtask
  // waits for irq (n = 0) or for the frame count to reach n, bounded
  task automatic wait_for(input int n);
    int k;
    k = 0;
    while ((n == 0 ? irq !== 1'b1 : fr_n < n) && k < 20000) begin
      @(posedge hclk);
      k++;
    end
    repeat (20) @(posedge hclk);
    check(n == 0 ? {31'h00000000, irq} : 32'(fr_n), n == 0 ? 32'h00000001 : 32'(n));
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      e = rd_q.pop_front();
      check(hrdata & e[63:32], e[31:0]);
    end
  end
  // each finished frame is matched against the oldest noted frame
  always @(fr_n) begin
    if (fr_n > 0) begin
      f = fr_q.pop_front();
      check(32'(peer_edges), {24'h000000, f[7:0]});
      check({28'h0000000, peer_cs}, {28'h0000000, f[11:8]});
      setup_a[fr_n % 16] = peer_setup;
      gap_a[fr_n % 16] = peer_gap;
    end
  end
  // cuts a hang short; the full run needs well under this
  initial begin
    repeat (60000) @(posedge hclk);
    err_total++;
    results();
  end
  initial begin
    {hresetn, hsel, hwrite, rd_ph, ss_low} = 5'h00;
    {haddr, hwdata} = 64'h0000000000000000;
    htrans = 2'b00;
    hsize = 3'b010;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(32'h17F0));
    rd(ADDR_CTRL0, 32'h00000104, 32'hFFFFFFFF);
    rd(ADDR_CTRL1, 32'h00000404, 32'hFFFFFFFF);
    rd(ADDR_CTRL2, 32'h00000000, 32'hFFFFFFFF);
    rd(ADDR_CTRL3, 32'h00000000, 32'hFFFFFFFF);
    r = $urandom;
    wr(ADDR_CTRL2, r);
    rd(ADDR_CTRL2, r & 32'h0000EF0F, 32'hFFFFFFFF);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h00000000, 32'hFFFFFFFF);
    done("registers");
    // four entries at a random place: byte, programmed width, delays
    s = 4'(3 + $urandom % 4);
    wr(ADDR_PORT, 32'h007E7F78);
    for (int i = 0; i < 4; i++) begin
      pc[i] = 4'($urandom % 15);
      fr_q.push_back({pc[i], i == 1 ? 8'h18 : 8'h10});
    end
    cmd(s, {4'h0, pc[0]});
    cmd(s + 1, {4'h5, pc[1]});
    cmd(s + 2, {4'h2, pc[2]});
    cmd(s + 3, {4'h0, pc[3]});
    wr(ADDR_CTRL0, 32'h0000B104);
    wr(ADDR_CTRL2, {16'h0000, 4'h8, 4'(s + 4'h3), 4'h0, s});
    wr(ADDR_CTRL1, 32'h00009402);
    wait_for(0);
    rd(ADDR_CTRL3, {24'h000000, 4'h8, 4'(s + 4'h3)}, 32'h000000FF);
    rd(ADDR_CTRL1, 32'h00000000, 32'h00008000);
    check({25'h0000000, pin_oe}, 32'h0000007E);
    check({25'h0000000, pin_out}, 32'h00000078);
    check(32'(setup_a[2] - setup_a[1]), 32'h00000010);
    check(32'(gap_a[4] - gap_a[3]), 32'h0000003F);
    wr(ADDR_CTRL3, 32'h00000000);
    repeat (3) @(posedge hclk);
    check({31'h00000000, irq}, 32'h00000000);
    done("queue");
    // halt requested right after start stops at the first boundary
    base = fr_n;
    for (int i = 0; i < 4; i++) begin
      pc[i] = 4'($urandom % 15);
      fr_q.push_back({pc[i], 8'h10});
      cmd(i, {4'h0, pc[i]});
    end
    wr(ADDR_CTRL2, 32'h00000300);
    wr(ADDR_CTRL3, 32'h00000200);
    wr(ADDR_CTRL1, 32'h00008000);
    wr(ADDR_CTRL3, 32'h00000300);
    wait_for(0);
    check(32'(fr_n - base), 32'h00000001);
    rd(ADDR_CTRL3, 32'h00000320, 32'h000007EF);
    wr(ADDR_CTRL3, 32'h00000000);
    wait_for(base + 4);
    check({31'h00000000, irq}, 32'h00000000);
    rd(ADDR_CTRL3, 32'h00000083, 32'h000000FF);
    done("halt");
    // continue bit keeps one select across all four entries
    base = fr_n;
    p = 4'($urandom % 15);
    fr_q.push_back({p, 8'h40});
    for (int i = 0; i < 4; i++) begin
      cmd(i, {i < 3 ? 4'h8 : 4'h0, p});
    end
    wr(ADDR_CTRL3, 32'h00000000);
    wr(ADDR_CTRL1, 32'h00008000);
    wait_for(base + 1);
    rd(ADDR_CTRL3, 32'h00000083, 32'h000000FF);
    done("continue");
    // wrap back to the start pointer repeats one entry, loop-back returns the byte
    base = fr_n;
    p = 4'($urandom % 15);
    for (int i = 0; i < 6; i++) begin
      fr_q.push_back({p, 8'h10});
    end
    cmd(1, {4'h0, p});
    r = $urandom;
    wr(ADDR_DATA, {24'h000000, r[7:0]});
    wr(ADDR_CTRL3, 32'h00000400);
    wr(ADDR_CTRL2, 32'h00006101);
    wr(ADDR_CTRL1, 32'h00008000);
    wait_for(base + 3);
    wr(ADDR_CTRL3, 32'h00000500);
    repeat (200) @(posedge hclk);
    rd(ADDR_CTRL3, 32'h000005A1, 32'h000007EF);
    rd(ADDR_DATA, {24'h000000, r[7:0]}, 32'h000000FF);
    wr(ADDR_CTRL1, 32'h00000000);
    done("wrap");
    // slave-select pulled low while enabled as master
    cmd(0, 8'h0F);
    ss_low <= 1'b1;
    wr(ADDR_CTRL2, 32'h00000000);
    wr(ADDR_PORT, 32'h00767F78);
    wr(ADDR_CTRL3, 32'h00000200);
    repeat (4) @(posedge hclk);
    wr(ADDR_CTRL1, 32'h00008000);
    wait_for(0);
    rd(ADDR_CTRL3, 32'h00000240, 32'h000007E0);
    rd(ADDR_CTRL1, 32'h00000000, 32'h00008000);
    done("fault");
    results();
  end
endmodule
